// [src/fcr_pkg.sv]
// constants and field layout for the flash configuration register bank
package fcr_pkg;

  // register selector codes presented by the command decoder
  localparam logic [1:0] SEL_IFACE_V   = 2'h0;
  localparam logic [1:0] SEL_IFACE_NV  = 2'h1;
  localparam logic [1:0] SEL_OPTS_NV   = 2'h2;
  localparam logic [1:0] SEL_OPTS_V    = 2'h3;

  // volatile interface config field positions
  localparam int unsigned IF_ADDR_LEN  = 7;
  localparam int unsigned IF_QUAD      = 6;
  localparam int unsigned IF_IO3_RST   = 5;
  localparam int unsigned IF_LAT_HI    = 3;
  localparam int unsigned IF_LAT_LO    = 0;
  localparam logic [7:0]  IF_WR_MASK   = 8'hef;

  // command option field positions
  localparam int unsigned OP_BLANK     = 5;
  localparam int unsigned OP_WRAP      = 4;
  localparam int unsigned OP_PARAM     = 3;
  localparam int unsigned OP_RESUME    = 2;
  localparam int unsigned OP_BLOCK     = 1;
  localparam int unsigned OP_LEGACY    = 0;
  localparam logic [7:0]  OP_WR_MASK   = 8'h3f;
  localparam logic [7:0]  OP_V_WR_MASK = 8'h37;
  localparam logic [7:0]  OP_PARAM_BIT = 8'h08;

  // reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;

  // effective address length in bytes
  localparam logic [2:0]  ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0]  ADDR_BYTES_4 = 3'h4;

  // page buffer wrap sizes in bytes
  localparam logic [9:0]  WRAP_256     = 10'h100;
  localparam logic [9:0]  WRAP_512     = 10'h200;

endpackage : fcr_pkg

// [src/fcr_regs.sv]
// flash interface and command option register bank
// Function
// - address-length bit picks four-byte when set, three-byte when clear
// - four-byte-address-mode command sets the address-length bit
// - quad-protocol bit selects four-bit wide instructions, else serial
// - writing quad-protocol set forces quad enable on; boot-copy loads and clearing leave it
// - io3 reset bit makes line three an active-low reset when idle or quad mode is off
// - four-bit latency field gives 0 to 15 dummy cycles on reads
// - nonvolatile option bits start zero, program once, load at reset
// - volatile option copy is writable during operation
// - blank-check bit enables erased-sector check before erase
// - page-wrap bit chooses 512-byte or 256-byte buffer wrap
// - parameter-sector bit removes small sectors for uniform layout
// - resume-select bit makes 30h resume, otherwise clear-status
// - block-erase-size bit picks 256-KB block or 64-KB sector erase
// - legacy-reset bit enables F0h soft reset, otherwise ignored
`timescale 1ns/1ps
`default_nettype none

module fcr_regs (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // register access from the command decoder
  input  wire logic       read_any_reg_cmd,
  input  wire logic       write_any_reg_cmd,
  input  wire logic [1:0] reg_sel,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // other commands
  input  wire logic       four_byte_addr_cmd,
  input  wire logic       soft_reset_cmd,
  input  wire logic       legacy_reset_cmd,
  // boot copy of the interface config, held outside
  input  wire logic [7:0] boot_interface_config,
  // pin state for the alternate reset
  input  wire logic       quad_line_three,
  input  wire logic       cs_n,
  input  wire logic       quad_mode_on,
  // interface controls
  output logic            addr_len_sel,
  output logic      [2:0] addr_bytes,
  output logic            quad_proto_en,
  output logic            quad_enable_set,
  output logic            io3_reset_en,
  output logic            io3_hw_reset,
  output logic      [3:0] read_dummy_count,
  // command option controls
  output logic            blank_check_en,
  output logic      [9:0] page_wrap_bytes,
  output logic            param_sector_remove,
  output logic            resume_select,
  output logic            block_erase_256k,
  output logic            legacy_soft_reset_en,
  output logic            legacy_reset_pulse
);

  // merges a write into a byte under a mask
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  logic [7:0] iface_q, iface_d;
  logic [7:0] opts_nv_q, opts_nv_d;
  logic [7:0] opts_v_q, opts_v_d;
  logic       boot_q, boot_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       qe_set_q, qe_set_d;
  logic       hw_rst_q, hw_rst_d;
  logic       leg_q, leg_d;
  logic       leg_accept;
  logic       reload;
  logic       wr_iface;
  logic       wr_opts_nv;
  logic       wr_opts_v;
  logic [7:0] iface_wr;

  always_comb begin
    leg_accept = legacy_reset_cmd & opts_v_q[fcr_pkg::OP_LEGACY];
    // line three low resets while bus idle or quad off
    hw_rst_d   = iface_q[fcr_pkg::IF_IO3_RST] & ~quad_line_three &
                 (cs_n | ~quad_mode_on);
    reload     = boot_q | soft_reset_cmd | leg_accept | hw_rst_q;
    // access only through the any-register commands
    wr_iface   = write_any_reg_cmd & (reg_sel == fcr_pkg::SEL_IFACE_V);
    wr_opts_nv = write_any_reg_cmd & (reg_sel == fcr_pkg::SEL_OPTS_NV);
    wr_opts_v  = write_any_reg_cmd & (reg_sel == fcr_pkg::SEL_OPTS_V);
    iface_wr   = merge(iface_q, reg_wdata, fcr_pkg::IF_WR_MASK);
    boot_d     = 1'b0;
    leg_d      = leg_accept;
    qe_set_d   = 1'b0;
    iface_d    = iface_q;
    opts_nv_d  = opts_nv_q;
    opts_v_d   = opts_v_q;

    // otp bits only ever move from zero to one
    if (wr_opts_nv) begin
      opts_nv_d = opts_nv_q | (reg_wdata & fcr_pkg::OP_WR_MASK);
    end

    if (reload) begin
      // interface fields come from the boot copy
      iface_d  = boot_interface_config & fcr_pkg::IF_WR_MASK;
      // option copy loads from the otp bits
      opts_v_d = opts_nv_q;
    end else begin
      if (wr_iface) begin
        iface_d = iface_wr;
        // entering quad protocol forces quad enable
        qe_set_d = reg_wdata[fcr_pkg::IF_QUAD];
      end
      // four-byte mode command sets address length
      if (four_byte_addr_cmd) begin
        iface_d[fcr_pkg::IF_ADDR_LEN] = 1'b1;
      end
      // volatile options writable, sector layout excluded
      if (wr_opts_v) begin
        opts_v_d = merge(opts_v_q, reg_wdata, fcr_pkg::OP_V_WR_MASK);
      end
      // layout bit follows only the otp copy
      if (wr_opts_nv) begin
        opts_v_d = merge(opts_v_d, opts_nv_d, fcr_pkg::OP_PARAM_BIT);
      end
    end
  end

  always_comb begin
    rvalid_d = read_any_reg_cmd;
    rdata_d  = rdata_q;
    // reserved bits are stored as zero, or masked off the boot copy, so read zero
    if (read_any_reg_cmd) begin
      if (reg_sel == fcr_pkg::SEL_IFACE_V) begin
        rdata_d = iface_q;
      end else if (reg_sel == fcr_pkg::SEL_IFACE_NV) begin
        rdata_d = boot_interface_config & fcr_pkg::IF_WR_MASK;
      end else if (reg_sel == fcr_pkg::SEL_OPTS_NV) begin
        rdata_d = opts_nv_q;
      end else begin
        rdata_d = opts_v_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iface_q   <= fcr_pkg::RST_BYTE;
      opts_nv_q <= fcr_pkg::RST_BYTE;
      opts_v_q  <= fcr_pkg::RST_BYTE;
      boot_q    <= 1'b1;
      rdata_q   <= fcr_pkg::RST_BYTE;
      rvalid_q  <= 1'b0;
      qe_set_q  <= 1'b0;
      hw_rst_q  <= 1'b0;
      leg_q     <= 1'b0;
    end else begin
      iface_q   <= iface_d;
      opts_nv_q <= opts_nv_d;
      opts_v_q  <= opts_v_d;
      boot_q    <= boot_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      qe_set_q  <= qe_set_d;
      hw_rst_q  <= hw_rst_d;
      leg_q     <= leg_d;
    end
  end

  // decoded controls, registered so outputs leave flops
  logic [2:0] abytes_q, abytes_d;
  logic [9:0] wrap_q, wrap_d;

  always_comb begin
    abytes_d = iface_d[fcr_pkg::IF_ADDR_LEN] ? fcr_pkg::ADDR_BYTES_4
                                             : fcr_pkg::ADDR_BYTES_3;
    wrap_d   = opts_v_d[fcr_pkg::OP_WRAP] ? fcr_pkg::WRAP_512
                                          : fcr_pkg::WRAP_256;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      abytes_q <= fcr_pkg::ADDR_BYTES_3;
      wrap_q   <= fcr_pkg::WRAP_256;
    end else begin
      abytes_q <= abytes_d;
      wrap_q   <= wrap_d;
    end
  end

  assign reg_rdata            = rdata_q;
  assign reg_rvalid           = rvalid_q;
  assign addr_len_sel         = iface_q[fcr_pkg::IF_ADDR_LEN];
  assign addr_bytes           = abytes_q;
  assign quad_proto_en        = iface_q[fcr_pkg::IF_QUAD];
  assign quad_enable_set      = qe_set_q;
  assign io3_reset_en         = iface_q[fcr_pkg::IF_IO3_RST];
  assign io3_hw_reset         = hw_rst_q;
  assign read_dummy_count     = iface_q[fcr_pkg::IF_LAT_HI:fcr_pkg::IF_LAT_LO];
  assign blank_check_en       = opts_v_q[fcr_pkg::OP_BLANK];
  assign page_wrap_bytes      = wrap_q;
  assign param_sector_remove  = opts_v_q[fcr_pkg::OP_PARAM];
  assign resume_select        = opts_v_q[fcr_pkg::OP_RESUME];
  assign block_erase_256k     = opts_v_q[fcr_pkg::OP_BLOCK];
  assign legacy_soft_reset_en = opts_v_q[fcr_pkg::OP_LEGACY];
  assign legacy_reset_pulse   = leg_q;

endmodule : fcr_regs

`default_nettype wire

// [tb/fcr_regs_asserts.sv]
// assertion checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module fcr_regs_asserts (
  // clock, reset and register access
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       read_any_reg_cmd,
  input wire logic       write_any_reg_cmd,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rvalid,
  // commands and pins
  input wire logic       four_byte_addr_cmd,
  input wire logic       soft_reset_cmd,
  input wire logic       legacy_reset_cmd,
  input wire logic [7:0] boot_interface_config,
  input wire logic       quad_line_three,
  input wire logic       cs_n,
  input wire logic       quad_mode_on,
  // controls
  input wire logic       addr_len_sel,
  input wire logic [2:0] addr_bytes,
  input wire logic       quad_proto_en,
  input wire logic       quad_enable_set,
  input wire logic       io3_reset_en,
  input wire logic       io3_hw_reset,
  input wire logic [3:0] read_dummy_count,
  input wire logic       legacy_soft_reset_en,
  input wire logic       legacy_reset_pulse
);
  logic up_q;
  logic calm;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) up_q <= 1'b0;
    else up_q <= 1'b1;
  // no reload competes with a request
  assign calm = up_q && !soft_reset_cmd && !legacy_reset_cmd
                && !io3_hw_reset;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (
    read_any_reg_cmd |=> reg_rvalid) else $error("read unanswered");
  a_addr_width: assert property (
    addr_bytes == (addr_len_sel ? 3'h4 : 3'h3)) else $error("addr width");
  a_four_byte: assert property (
    four_byte_addr_cmd && calm && !write_any_reg_cmd |=> addr_len_sel)
    else $error("four byte mode not set");
  a_quad_force: assert property (
    write_any_reg_cmd && reg_sel == 2'h0 && reg_wdata[6] && calm
    |=> quad_proto_en && quad_enable_set) else $error("quad not forced");
  a_quad_cause: assert property (
    quad_enable_set |-> $past(write_any_reg_cmd) && $past(reg_wdata[6])
    && $past(reg_sel) == 2'h0) else $error("stray quad enable");
  a_io3_fire: assert property (
    io3_reset_en && !quad_line_three && (cs_n || !quad_mode_on)
    |=> io3_hw_reset) else $error("line three reset missed");
  a_io3_cause: assert property (
    io3_hw_reset |-> $past(io3_reset_en) && !$past(quad_line_three)
    && ($past(cs_n) || !$past(quad_mode_on)))
    else $error("stray line three reset");
  a_legacy_gate: assert property (
    legacy_reset_pulse |-> $past(legacy_reset_cmd)
    && $past(legacy_soft_reset_en)) else $error("legacy reset not gated");
  a_boot_load: assert property (
    soft_reset_cmd |=> {addr_len_sel, quad_proto_en, io3_reset_en, 1'b0,
    read_dummy_count} == ($past(boot_interface_config) & 8'hef))
    else $error("boot load wrong");
  c_read: cover property (reg_rvalid);
  c_quad: cover property (quad_enable_set);
  c_legacy: cover property (legacy_reset_pulse);
  c_io3: cover property (io3_hw_reset);
endmodule : fcr_regs_asserts
bind fcr_regs fcr_regs_asserts u_fcr_regs_asserts (.*);
`default_nettype wire

// [tb/fcr_host.sv]
// host model issuing register read and write commands
`timescale 1ns/1ps
`default_nettype none
module fcr_host (
  // clock
  input  wire logic       ref_clk,
  // register access
  output logic            read_any_reg_cmd,
  output logic            write_any_reg_cmd,
  output logic      [1:0] reg_sel,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    read_any_reg_cmd = 1'b0;
    write_any_reg_cmd = 1'b0;
    reg_sel = 2'h0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    write_any_reg_cmd <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge ref_clk);
    write_any_reg_cmd <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge ref_clk);
    read_any_reg_cmd <= 1'b1;
    reg_sel <= s;
    @(posedge ref_clk);
    read_any_reg_cmd <= 1'b0;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd
endmodule : fcr_host
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       ref_clk = 1'b0;
  logic       rst_n, read_any_reg_cmd, write_any_reg_cmd, reg_rvalid;
  logic [1:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata, boot_interface_config;
  logic       four_byte_addr_cmd, soft_reset_cmd, legacy_reset_cmd;
  logic       quad_line_three, cs_n, quad_mode_on, addr_len_sel;
  logic [2:0] addr_bytes;
  logic       quad_proto_en, quad_enable_set, io3_reset_en, io3_hw_reset;
  logic [3:0] read_dummy_count;
  logic [9:0] page_wrap_bytes;
  logic       blank_check_en, param_sector_remove, resume_select;
  logic       block_erase_256k, legacy_soft_reset_en, legacy_reset_pulse;
  int         bad_count = 0;
  int         checks = 0;
  fcr_regs u_fcr_regs (.*);
  fcr_host u_fcr_host (.*);
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [1:0] s, input logic [7:0] e);
    logic [7:0] v;
    u_fcr_host.rd(s, v);
    chk({2'h0, v}, {2'h0, e});
  endtask : rchk
  // bit 3 pulls line three low, bits 2:0 pulse legacy, soft, four-byte
  task automatic kick(input logic [3:0] k);
    @(posedge ref_clk);
    {quad_line_three, legacy_reset_cmd, soft_reset_cmd,
     four_byte_addr_cmd} <= k ^ 4'h8;
    @(posedge ref_clk);
    {quad_line_three, legacy_reset_cmd, soft_reset_cmd,
     four_byte_addr_cmd} <= 4'h8;
    #1;
  endtask : kick
  task automatic conclude();
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    rst_n = 1'b0;
    {quad_line_three, legacy_reset_cmd, soft_reset_cmd,
     four_byte_addr_cmd} = 4'h8;
    boot_interface_config = 8'hb5;
    cs_n = 1'b1;
    quad_mode_on = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rchk(2'h0, 8'ha5);
    chk({9'h0, io3_reset_en}, 10'h001);
    rchk(2'h1, 8'ha5);
    rchk(2'h2, 8'h00);
    u_fcr_host.wr(2'h0, 8'h5f);
    chk({9'h0, quad_enable_set}, 10'h001);
    chk({9'h0, io3_reset_en}, 10'h000);
    rchk(2'h0, 8'h4f);
    chk({6'h0, read_dummy_count}, 10'h00f);
    chk({9'h0, quad_proto_en}, 10'h001);
    chk({7'h0, addr_bytes}, 10'h003);
    kick(4'h1);
    chk({7'h0, addr_bytes}, 10'h004);
    chk({9'h0, addr_len_sel}, 10'h001);
    u_fcr_host.wr(2'h2, 8'hff);
    u_fcr_host.wr(2'h2, 8'h00);
    rchk(2'h2, 8'h3f);
    kick(4'h2);
    rchk(2'h3, 8'h3f);
    rchk(2'h0, 8'ha5);
    chk(page_wrap_bytes, 10'h200);
    chk({5'h0, blank_check_en, param_sector_remove, resume_select,
         block_erase_256k, legacy_soft_reset_en}, 10'h01f);
    u_fcr_host.wr(2'h3, 8'h00);
    rchk(2'h3, 8'h08);
    chk(page_wrap_bytes, 10'h100);
    kick(4'h4);
    chk({9'h0, legacy_reset_pulse}, 10'h000);
    u_fcr_host.wr(2'h3, 8'h01);
    kick(4'h4);
    chk({9'h0, legacy_reset_pulse}, 10'h001);
    kick(4'h8);
    chk({9'h0, io3_hw_reset}, 10'h001);
    @(posedge ref_clk);
    cs_n         <= 1'b0;
    quad_mode_on <= 1'b1;
    kick(4'h8);
    chk({9'h0, io3_hw_reset}, 10'h000);
    @(posedge ref_clk);
    quad_mode_on <= 1'b0;
    kick(4'h8);
    chk({9'h0, io3_hw_reset}, 10'h001);
    @(posedge ref_clk);
    cs_n <= 1'b1;
    u_fcr_host.wr(2'h0, 8'h00);
    chk({9'h0, quad_enable_set}, 10'h000);
    kick(4'h8);
    chk({9'h0, io3_hw_reset}, 10'h000);
    conclude();
  end
endmodule : testbench
`default_nettype wire
